/* File: design/thread_ctl_pkg.sv */
// shared constants and types for the thread state and control block
package thread_ctl_pkg;

  // ----------------------------------------
  // register operand decode
  // ----------------------------------------
  localparam logic [3:0] CTRL_TYPE_CODE   = 4'h8;
  localparam logic [3:0] CTRL_REG_NUM     = 4'h0;
  localparam logic [4:0] SUB_GENERAL      = 5'h00;
  localparam logic [4:0] SUB_EXCEPTION    = 5'h04;
  localparam logic [4:0] SUB_SAVED_PTR    = 5'h08;
  localparam logic [4:0] SUB_RESERVED     = 5'h0c;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int SLOT_ID_MSB      = 2;
  localparam int FF_ID_LSB        = 24;
  localparam int MASTER_EXC_BIT   = 31;
  localparam int EXC_COUNT        = 16;
  localparam int EXC_STATUS_LSB   = 16;
  localparam int GROUP_SIZE       = 4;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [31:0] WORD_RESET      = 32'h0000_0000;
  localparam logic [31:0] SYS_PTR_RESET   = 32'h0000_0000;
  localparam logic [31:0] RESERVED_READ   = 32'h0000_0000;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [2:0]  thread_slot_id;
    logic [7:0]  fixed_function_thread_id;
    logic [31:0] dispatch_channel_mask;
    logic [31:0] initial_pointer;
  } dispatch_t;

  typedef struct packed {
    logic [7:0]  reg_num;
    logic [4:0]  sub_reg_num;
  } operand_t;

  typedef enum logic [1:0] {REDIRECT_NONE, REDIRECT_SYSTEM, REDIRECT_RESUME} redirect_t;

endpackage

/* File: design/thread_state_exception_control.sv */
// per-thread state words, control register group and exception redirect
// What this block does
// - load three-bit slot id at dispatch
// - keep fixed-function id in top byte
// - store dispatch channel mask, seeds mask
// - vector mask: OR of each 4-bit group
// - control group selected by type code 1000b
// - four 32-bit subregisters, first three readable and writable
// - jump only if exception enabled
// - status bit set even when disabled
// - one bit each, higher priority higher bit
// - third subregister holds saved instruction pointer
// - writes to fourth subregister dropped
// - one hidden global system routine address
// - save pointer, then jump to system routine
// - clearing master bit resumes at saved pointer
// - decode subregister numbers 0, 4, 8, 12
// - master bit: hw sets, write zero returns
module thread_state_exception_control
  import thread_ctl_pkg::*;
#(
  parameter int unsigned DATA_W = 32
) (
  // clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              ARST_N,
  // dispatcher
  input  wire logic              DISPATCH_VALID,
  input  wire dispatch_t         DISPATCH_INFO,
  input  wire logic              SYS_PTR_LOAD,
  input  wire logic [DATA_W-1:0] SYS_PTR_VALUE,
  // pipeline register access
  input  wire logic              REG_WRITE,
  input  wire operand_t          REG_OPERAND,
  input  wire logic [DATA_W-1:0] REG_WDATA,
  output logic      [DATA_W-1:0] REG_RDATA,
  output logic                   REG_HIT,
  // pipeline exceptions and pointer
  input  wire logic [EXC_COUNT-1:0] EXC_EVENT,
  input  wire logic [DATA_W-1:0] CURRENT_IP,
  output logic                   REDIRECT_VALID,
  output logic      [DATA_W-1:0] REDIRECT_IP,
  output logic      [DATA_W-1:0] STATE_WORD0,
  output logic      [DATA_W-1:0] STATE_WORD1,
  output logic      [DATA_W-1:0] STATE_WORD2,
  output logic      [DATA_W-1:0] STATE_WORD3,
  output logic      [DATA_W-1:0] MASK_INIT,
  output logic                   EXCEPTION_STATE
);

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  logic [2:0]        slot_reg, slot_next;
  logic [7:0]        ffid_reg, ffid_next;
  logic [DATA_W-1:0] dispatch_channel_mask_reg, dispatch_channel_mask_next;
  logic [DATA_W-1:0] vector_group_mask_reg, vector_group_mask_next;
  logic [DATA_W-1:0] general_reg, general_next;
  logic [DATA_W-1:0] exc_reg, exc_next;
  logic [DATA_W-1:0] saved_reg, saved_next;
  logic [DATA_W-1:0] sys_ptr_reg, sys_ptr_next;
  logic [DATA_W-1:0] redir_ip_reg, redir_ip_next;
  redirect_t         redir_reg, redir_next;

  logic              sel_group;
  logic              sel_general;
  logic              sel_exc;
  logic              sel_saved;
  logic              sel_rsvd;
  logic [DATA_W-1:0] vector_group_mask_calc;
  logic [EXC_COUNT-1:0] take_vec;
  logic              take;
  logic              resume;

  // ----------------------------------------
  // vector group mask
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < DATA_W / GROUP_SIZE; g++) begin : grp
      assign vector_group_mask_calc[g*GROUP_SIZE +: GROUP_SIZE] =
        {GROUP_SIZE{|DISPATCH_INFO.dispatch_channel_mask[g*GROUP_SIZE +: GROUP_SIZE]}};
    end
  endgenerate

  // ----------------------------------------
  // operand decode
  // ----------------------------------------
  always_comb begin
    sel_group   = (REG_OPERAND.reg_num[7:4] == CTRL_TYPE_CODE) &&
                  (REG_OPERAND.reg_num[3:0] == CTRL_REG_NUM);
    sel_general = 1'b0;
    sel_exc     = 1'b0;
    sel_saved   = 1'b0;
    sel_rsvd    = 1'b0;
    if (sel_group && REG_OPERAND.sub_reg_num == SUB_GENERAL) begin
      sel_general = 1'b1;
    end else if (sel_group && REG_OPERAND.sub_reg_num == SUB_EXCEPTION) begin
      sel_exc = 1'b1;
    end else if (sel_group && REG_OPERAND.sub_reg_num == SUB_SAVED_PTR) begin
      sel_saved = 1'b1;
    end else if (sel_group && REG_OPERAND.sub_reg_num == SUB_RESERVED) begin
      sel_rsvd = 1'b1;
    end
  end

  // ----------------------------------------
  // exception detection
  // ----------------------------------------
  always_comb begin
    // bit position is priority, status above enables
    take_vec = EXC_EVENT & exc_reg[EXC_COUNT-1:0];
    take     = (|take_vec) && !general_reg[MASTER_EXC_BIT];
    resume   = REG_WRITE && sel_general && general_reg[MASTER_EXC_BIT] &&
               !REG_WDATA[MASTER_EXC_BIT];
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    slot_next     = slot_reg;
    ffid_next     = ffid_reg;
    dispatch_channel_mask_next    = dispatch_channel_mask_reg;
    vector_group_mask_next    = vector_group_mask_reg;
    general_next  = general_reg;
    exc_next      = exc_reg;
    saved_next    = saved_reg;
    sys_ptr_next  = sys_ptr_reg;
    redir_next    = REDIRECT_NONE;
    redir_ip_next = redir_ip_reg;

    if (SYS_PTR_LOAD) begin
      sys_ptr_next = SYS_PTR_VALUE;
    end

    if (DISPATCH_VALID) begin
      slot_next    = DISPATCH_INFO.thread_slot_id;
      ffid_next    = DISPATCH_INFO.fixed_function_thread_id;
      dispatch_channel_mask_next   = DISPATCH_INFO.dispatch_channel_mask;
      vector_group_mask_next   = vector_group_mask_calc;
      general_next = WORD_RESET;
      exc_next     = WORD_RESET;
      saved_next   = DISPATCH_INFO.initial_pointer;
    end else begin
      // software writes first, hardware events override
      if (REG_WRITE && sel_general) begin
        general_next = {general_reg[MASTER_EXC_BIT], REG_WDATA[DATA_W-2:0]};
        if (resume) begin
          general_next[MASTER_EXC_BIT] = 1'b0;
        end
      end
      if (REG_WRITE && sel_exc) begin
        exc_next = REG_WDATA;
      end
      if (REG_WRITE && sel_saved) begin
        saved_next = REG_WDATA;
      end
      // reserved word writes fall through unused
      exc_next[DATA_W-1:EXC_STATUS_LSB] =
        exc_next[DATA_W-1:EXC_STATUS_LSB] | EXC_EVENT;
      if (take) begin
        saved_next                   = CURRENT_IP;
        general_next[MASTER_EXC_BIT] = 1'b1;
        redir_next                   = REDIRECT_SYSTEM;
        redir_ip_next                = sys_ptr_reg;
      end else if (resume) begin
        redir_next    = REDIRECT_RESUME;
        redir_ip_next = saved_reg;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      slot_reg     <= 3'h0;
      ffid_reg     <= 8'h00;
      dispatch_channel_mask_reg    <= WORD_RESET;
      vector_group_mask_reg    <= WORD_RESET;
      general_reg  <= WORD_RESET;
      exc_reg      <= WORD_RESET;
      saved_reg    <= WORD_RESET;
      sys_ptr_reg  <= SYS_PTR_RESET;
      redir_reg    <= REDIRECT_NONE;
      redir_ip_reg <= WORD_RESET;
    end else begin
      slot_reg     <= slot_next;
      ffid_reg     <= ffid_next;
      dispatch_channel_mask_reg    <= dispatch_channel_mask_next;
      vector_group_mask_reg    <= vector_group_mask_next;
      general_reg  <= general_next;
      exc_reg      <= exc_next;
      saved_reg    <= saved_next;
      sys_ptr_reg  <= sys_ptr_next;
      redir_reg    <= redir_next;
      redir_ip_reg <= redir_ip_next;
    end
  end

  // ----------------------------------------
  // read path and outputs
  // ----------------------------------------
  always_comb begin
    REG_HIT   = sel_general | sel_exc | sel_saved | sel_rsvd;
    REG_RDATA = WORD_RESET;
    if (sel_general) begin
      REG_RDATA = general_reg;
    end else if (sel_exc) begin
      REG_RDATA = exc_reg;
    end else if (sel_saved) begin
      REG_RDATA = saved_reg;
    end else if (sel_rsvd) begin
      REG_RDATA = RESERVED_READ;
    end
  end

  assign STATE_WORD0     = {{(DATA_W-SLOT_ID_MSB-1){1'b0}}, slot_reg};
  assign STATE_WORD1     = {ffid_reg, {FF_ID_LSB{1'b0}}};
  assign STATE_WORD2     = dispatch_channel_mask_reg;
  assign STATE_WORD3     = vector_group_mask_reg;
  assign MASK_INIT       = dispatch_channel_mask_reg & vector_group_mask_reg;
  assign EXCEPTION_STATE = general_reg[MASTER_EXC_BIT];
  assign REDIRECT_VALID  = (redir_reg != REDIRECT_NONE);
  assign REDIRECT_IP     = redir_ip_reg;

endmodule

/* File: sim/thread_ctl_checker.sv */
// assertion checker for the thread state and control block
module thread_ctl_checker
  import thread_ctl_pkg::*;
#(parameter int unsigned DATA_W = 32) (
  // watched ports
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic DISPATCH_VALID,
  input wire dispatch_t DISPATCH_INFO,
  input wire logic SYS_PTR_LOAD,
  input wire logic [DATA_W-1:0] SYS_PTR_VALUE,
  input wire logic REG_WRITE,
  input wire operand_t REG_OPERAND,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic [EXC_COUNT-1:0] EXC_EVENT,
  input wire logic REG_HIT,
  input wire logic REDIRECT_VALID,
  input wire logic [DATA_W-1:0] REDIRECT_IP,
  input wire logic [DATA_W-1:0] STATE_WORD0,
  input wire logic [DATA_W-1:0] STATE_WORD1,
  input wire logic [DATA_W-1:0] STATE_WORD2,
  input wire logic [DATA_W-1:0] STATE_WORD3,
  input wire logic [DATA_W-1:0] MASK_INIT,
  input wire logic EXCEPTION_STATE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] sys_reg, sys_next;
  always_comb sys_next = SYS_PTR_LOAD ? SYS_PTR_VALUE : sys_reg;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) sys_reg <= '0;
    else sys_reg <= sys_next;
  end
  function automatic logic [31:0] grp_or(input logic [31:0] m);
    for (int g = 0; g < 8; g++) grp_or[4*g+:4] = {4{|m[4*g+:4]}};
  endfunction
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_take; !EXCEPTION_STATE ##1 EXCEPTION_STATE; endsequence
  sequence s_back; EXCEPTION_STATE && REG_WRITE && REG_HIT && !REG_WDATA[MASTER_EXC_BIT]
    && REG_OPERAND.sub_reg_num == SUB_GENERAL && !DISPATCH_VALID; endsequence
  a_slot_load: assert property (DISPATCH_VALID |=>
    STATE_WORD0[2:0] == $past(DISPATCH_INFO.thread_slot_id)) else $error("slot id wrong");
  a_ffid_load: assert property (DISPATCH_VALID |=>
    STATE_WORD1[31:24] == $past(DISPATCH_INFO.fixed_function_thread_id)) else $error("ffid wrong");
  a_dispatch_channel_mask_load: assert property (DISPATCH_VALID |=>
    STATE_WORD2 == $past(DISPATCH_INFO.dispatch_channel_mask)) else $error("dispatch_channel_mask wrong");
  a_vector_group_mask_groups: assert property (STATE_WORD3 == grp_or(STATE_WORD2) &&
    MASK_INIT == (STATE_WORD2 & STATE_WORD3)) else $error("vector mask wrong");
  a_hit_decode: assert property (REG_HIT == (REG_OPERAND.reg_num == 8'h80 &&
    REG_OPERAND.sub_reg_num inside {5'h00, 5'h04, 5'h08, 5'h0c})) else $error("decode wrong");
  a_redirect_cause: assert property (REDIRECT_VALID |->
    $past(EXC_EVENT) != '0 || $past(EXCEPTION_STATE)) else $error("redirect without cause");
  a_take_target: assert property (s_take |->
    REDIRECT_VALID && REDIRECT_IP == sys_reg) else $error("take target wrong");
  a_resume_pulse: assert property (s_back |=>
    REDIRECT_VALID && !EXCEPTION_STATE) else $error("no resume");
  a_single_jump: assert property (REDIRECT_VALID && EXCEPTION_STATE |=>
    !REDIRECT_VALID || !EXCEPTION_STATE) else $error("repeated jump");
endmodule
bind thread_state_exception_control thread_ctl_checker #(.DATA_W(DATA_W)) chk_u (.*);

/* File: sim/ip_pipe_model.sv */
// pipeline pointer model: steps one word a cycle, follows redirects
module ip_pipe_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic redir,
  input wire logic [31:0] target,
  output logic [31:0] ip
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] ip_next;
  always_comb ip_next = redir ? target : ip + 32'h4;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ip <= 32'h0;
    else ip <= ip_next;
  end
endmodule

/* File: sim/thread_state_exception_control_test.sv */
// self-checking bench for the thread state and control block
module thread_state_exception_control_test
  import thread_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, dv, spl, we, rv, hit, es;
  dispatch_t di;
  operand_t op;
  logic [31:0] spv, wd, rdat, cip, rip, w0, w1, w2, w3, mi, ip_take;
  logic [15:0] ev;
  int failures, tests_run;
  thread_state_exception_control dut_u (
    .REF_CLK(clk), .ARST_N(rst_n), .DISPATCH_VALID(dv), .DISPATCH_INFO(di),
    .SYS_PTR_LOAD(spl), .SYS_PTR_VALUE(spv), .REG_WRITE(we), .REG_OPERAND(op),
    .REG_WDATA(wd), .REG_RDATA(rdat), .REG_HIT(hit), .EXC_EVENT(ev), .CURRENT_IP(cip),
    .REDIRECT_VALID(rv), .REDIRECT_IP(rip), .STATE_WORD0(w0), .STATE_WORD1(w1),
    .STATE_WORD2(w2), .STATE_WORD3(w3), .MASK_INIT(mi), .EXCEPTION_STATE(es));
  ip_pipe_model pipe_u (.clk(clk), .rst_n(rst_n), .redir(rv), .target(rip), .ip(cip));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] r, input logic [4:0] s, input logic [31:0] d);
    op = '{r, s};
    wd = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask
  task automatic rd(input logic [4:0] s, input logic [31:0] e);
    op = '{8'h80, s};
    #1 chk(rdat, e);
    @(negedge clk);
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog: tests need well under 200 cycles
  initial begin
    #20000;
    failures++;
    final_report;
  end
  initial begin
    rst_n = 1'b0; dv = 1'b0; di = '0; spl = 1'b0; spv = '0; ev = '0;
    we = 1'b0; op = '0; wd = '0; failures = 0; tests_run = 0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    di = '{3'h5, 8'ha5, 32'h0f00_1020, 32'h0000_0100};
    dv = 1'b1;
    @(negedge clk);
    dv = 1'b0;
    chk(w0 & 32'h7, 32'h5);
    chk(w1 & 32'hff00_0000, 32'ha500_0000);
    chk(w2, 32'h0f00_1020);
    chk(w3, 32'h0f00_f0f0);
    chk(mi, 32'h0f00_1020);
    rd(SUB_SAVED_PTR, 32'h0000_0100);
    $display("test dispatch done");
    wr(8'h80, SUB_GENERAL, 32'h8000_1234);
    rd(SUB_GENERAL, 32'h0000_1234);
    wr(8'h80, SUB_RESERVED, 32'hffff_ffff);
    rd(SUB_RESERVED, RESERVED_READ);
    wr(8'h80, SUB_SAVED_PTR, 32'h0000_0200);
    rd(SUB_SAVED_PTR, 32'h0000_0200);
    wr(8'h81, SUB_GENERAL, 32'h0000_5555);
    rd(SUB_GENERAL, 32'h0000_1234);
    rd(5'h14, 32'h0);
    chk({31'h0, hit}, 32'h0);
    $display("test registers done");
    spv = 32'h0000_4000;
    spl = 1'b1;
    @(negedge clk);
    spl = 1'b0;
    ev = 16'h0008;
    @(negedge clk);
    ev = '0;
    chk({31'h0, rv}, 32'h0);
    rd(SUB_EXCEPTION, 32'h0008_0000);
    wr(8'h80, SUB_EXCEPTION, 32'h0000_8001);
    ev = 16'h8001;
    ip_take = cip;
    @(negedge clk);
    ev = '0;
    chk({31'h0, rv}, 32'h1);
    chk(rip, 32'h0000_4000);
    chk({31'h0, es}, 32'h1);
    rd(SUB_EXCEPTION, 32'h8001_8001);
    rd(SUB_SAVED_PTR, ip_take);
    ev = 16'h0001;
    @(negedge clk);
    ev = '0;
    chk({31'h0, rv}, 32'h0);
    wr(8'h80, SUB_GENERAL, 32'h0000_0000);
    chk({31'h0, rv}, 32'h1);
    chk(rip, ip_take);
    chk({31'h0, es}, 32'h0);
    $display("test exceptions done");
    final_report;
  end
endmodule
